// >>> asg_acq_gate.sv
`default_nettype none
`include "asg_defs.svh"

module asg_acq_gate #(
	parameter int POINTS     = 256,
	parameter int FIFO_DEPTH = 16
)(
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire asg_pkg::asg_front_type front,
	input  wire asg_pkg::asg_bus_type bus,
	output logic [31:0]               rdata,
	output var asg_pkg::asg_host_type host_out,
	input  wire logic                 host_ready,
	output logic                      link_tx,
	output logic                      link_oe,
	output logic                      acq_busy
);
	import asg_pkg::*;

	localparam int PW = $clog2(POINTS);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		asg_fsm_type        fsm;
		logic [2:0]         div;
		logic               auto_gain;
		logic [7:0]         decim;
		logic [15:0]        scans;
		logic [PW:0]        npts;
		logic [6:0]         gain;
		logic [23:0]        adj;
		logic [15:0]        scan_cnt;
		logic [PW:0]        point;
		logic               dwell_d;
		logic signed [19:0] box_sum;
		logic [7:0]         box_cnt;
		logic [11:0]        peak;
		logic [1:0]         phase;
		logic [PW:0]        dump_addr;
		logic               dump_ok;
		logic               done;
		logic [31:0]        rdata;
		logic [4:0]         lbit;
		logic [15:0]        lbaud;
		logic [24:0]        lsh;
		logic               tx;
		logic               oe;
		logic               pend_gain;
		logic               pend_adj;
		logic               busy;
	} asg_state_type;

	asg_state_type      st_ff;
	asg_state_type      nxt_st;
	logic [31:0]        acc_mem [POINTS];
	logic [31:0]        mem_rd_ff;
	logic               tick;
	logic               take;
	logic               box_full;
	logic               scan_end;
	logic               last_scan;
	logic               mem_we;
	logic [PW-1:0]      mem_addr;
	logic [31:0]        mem_wdata;
	logic signed [11:0] raw;
	logic signed [12:0] val;
	logic signed [19:0] box_new;
	logic [11:0]        mag;
	logic               fifo_in_valid;
	logic               fifo_in_ready;

	// Register read decode
	function automatic logic [31:0] reg_read(input logic [7:0] a, input asg_state_type s);
		reg_read = 32'h0;
		case (a)
			`ASG_REG_CTRL:   reg_read = {16'h0, s.decim, 6'h0, s.auto_gain, 1'b0};
			`ASG_REG_SCANS:  reg_read = {16'h0, s.scans};
			`ASG_REG_GAIN:   reg_read = {25'h0, s.gain};
			`ASG_REG_ADJ:    reg_read = {8'h0, s.adj};
			`ASG_REG_STATUS: reg_read = {s.scan_cnt, 11'h0, s.oe, s.done, s.busy, s.fsm};
			`ASG_REG_POINTS: reg_read = 32'(s.npts);
			default:         reg_read = 32'h0;
		endcase
	endfunction : reg_read

	// ----------------------------------------
	// Datapath terms
	// ----------------------------------------
	// Sample tick at the reference rate, sample gating and boxcar decimation
	assign tick      = st_ff.div == 3'd0;
	assign take      = tick && front.dwell_enable && st_ff.fsm == ASG_ACQ;
	assign raw       = front.converter_gate ? signed'(front.data) : 12'sh0;
	assign val       = st_ff.phase[1] ? -13'(raw) : 13'(raw);
	assign box_new   = st_ff.box_sum + 20'(val);
	assign box_full  = take && (st_ff.box_cnt + 8'd1 >= st_ff.decim);
	assign mem_we    = box_full && st_ff.point < st_ff.npts;
	assign mem_wdata = (st_ff.scan_cnt == 16'h0 ? 32'h0 : mem_rd_ff) + 32'(box_new);
	assign mem_addr  = st_ff.fsm == ASG_DUMP ? st_ff.dump_addr[PW-1:0] : st_ff.point[PW-1:0];
	assign scan_end  = st_ff.fsm == ASG_ACQ && st_ff.dwell_d && !front.dwell_enable;
	assign last_scan = st_ff.scan_cnt + 16'd1 == st_ff.scans;
	assign mag       = front.data[11] ? ~front.data + 12'h1 : front.data;
	assign fifo_in_valid = st_ff.fsm == ASG_DUMP && st_ff.dump_ok;

	// Outputs
	assign rdata    = st_ff.rdata;
	assign link_tx  = st_ff.tx;
	assign link_oe  = st_ff.oe;
	assign acq_busy = st_ff.busy;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		nxt_st         = st_ff;
		nxt_st.div     = tick ? 3'(`ASG_TICK_DIV - 1) : st_ff.div - 3'd1;
		nxt_st.dwell_d = front.dwell_enable;

		// Serial link to the receiver board, one frame at a time
		if (!st_ff.oe)
		begin
			if (st_ff.pend_gain || st_ff.pend_adj)
			begin
				nxt_st.oe    = 1'b1;
				nxt_st.tx    = 1'b0;
				nxt_st.lbit  = `ASG_FRAME_BITS - 5'd1;                       // Shifts after the start bit
				nxt_st.lbaud = 16'(`ASG_LINK_BIT_CYC - 1);
				if (st_ff.pend_gain)
				begin
					nxt_st.lsh       = {1'b1, 16'h0, st_ff.gain, 1'b0};
					nxt_st.pend_gain = 1'b0;
				end
				else
				begin
					nxt_st.lsh      = {1'b1, st_ff.adj[22:0], 1'b1};
					nxt_st.pend_adj = 1'b0;
				end
			end
		end
		else if (st_ff.lbaud != 16'h0)
			nxt_st.lbaud = st_ff.lbaud - 16'h1;
		else if (st_ff.lbit == 5'd0)
		begin
			nxt_st.oe = 1'b0;
			nxt_st.tx = 1'b1;
		end
		else
		begin
			nxt_st.tx    = st_ff.lsh[0];
			nxt_st.lsh   = {1'b1, st_ff.lsh[24:1]};
			nxt_st.lbit  = st_ff.lbit - 5'd1;
			nxt_st.lbaud = 16'(`ASG_LINK_BIT_CYC - 1);
		end

		// Acquisition, accumulation and dump sequence
		unique case (st_ff.fsm)
			ASG_IDLE, ASG_DONE:
			begin
			end
			ASG_ACQ:
			begin
				if (take)
				begin
					if (mag > st_ff.peak)
						nxt_st.peak = mag;
					if (box_full)
					begin
						nxt_st.box_sum = 20'sh0;
						nxt_st.box_cnt = 8'h0;
						if (mem_we)
							nxt_st.point = st_ff.point + (PW+1)'(1);
					end
					else
					begin
						nxt_st.box_sum = box_new;
						nxt_st.box_cnt = st_ff.box_cnt + 8'd1;
					end
				end
				if (scan_end)
				begin
					nxt_st.scan_cnt = st_ff.scan_cnt + 16'd1;
					nxt_st.point    = '0;
					nxt_st.box_sum  = 20'sh0;
					nxt_st.box_cnt  = 8'h0;
					nxt_st.phase    = st_ff.phase + 2'd1;
					nxt_st.peak     = 12'h0;
					if (st_ff.auto_gain && st_ff.peak > `ASG_PEAK_HI && st_ff.gain != 7'h0)
					begin
						nxt_st.gain      = st_ff.gain - 7'd1;
						nxt_st.pend_gain = 1'b1;
					end
					else if (st_ff.auto_gain && st_ff.peak < `ASG_PEAK_LO && st_ff.gain != `ASG_GAIN_MAX)
					begin
						nxt_st.gain      = st_ff.gain + 7'd1;
						nxt_st.pend_gain = 1'b1;
					end
					if (last_scan)
					begin
						nxt_st.fsm       = ASG_DUMP;
						nxt_st.dump_addr = '0;
						nxt_st.dump_ok   = 1'b0;
					end
				end
			end
			ASG_DUMP:
			begin
				if (!st_ff.dump_ok)
					nxt_st.dump_ok = 1'b1;
				else if (fifo_in_ready)
				begin
					nxt_st.dump_ok   = 1'b0;
					nxt_st.dump_addr = st_ff.dump_addr + (PW+1)'(1);
					if (st_ff.dump_addr + (PW+1)'(1) >= st_ff.npts)
					begin
						nxt_st.fsm  = ASG_DONE;
						nxt_st.done = 1'b1;
					end
				end
			end
		endcase

		// Register writes come last so a new request wins over a launch
		if (bus.wr)
		begin
			case (bus.addr)
				`ASG_REG_CTRL:
				begin
					nxt_st.auto_gain = bus.wdata[`ASG_CTRL_AUTO];
					nxt_st.decim     = bus.wdata[`ASG_CTRL_DEC_LSB +: 8] == 8'h0 ? 8'h1
					                   : bus.wdata[`ASG_CTRL_DEC_LSB +: 8];
					if (bus.wdata[`ASG_CTRL_START] && (st_ff.fsm == ASG_IDLE || st_ff.fsm == ASG_DONE))
					begin
						nxt_st.fsm      = ASG_ACQ;
						nxt_st.scan_cnt = 16'h0;
						nxt_st.point    = '0;
						nxt_st.box_sum  = 20'sh0;
						nxt_st.box_cnt  = 8'h0;
						nxt_st.phase    = 2'd0;
						nxt_st.peak     = 12'h0;
						nxt_st.done     = 1'b0;
					end
				end
				`ASG_REG_SCANS:
					nxt_st.scans = bus.wdata[15:0];
				`ASG_REG_GAIN:
				begin
					nxt_st.gain      = bus.wdata[6:0];
					nxt_st.pend_gain = 1'b1;
				end
				`ASG_REG_ADJ:
				begin
					nxt_st.adj      = bus.wdata[23:0];
					nxt_st.pend_adj = 1'b1;
				end
				`ASG_REG_POINTS:
					nxt_st.npts = bus.wdata[PW:0] > (PW+1)'(POINTS) ? (PW+1)'(POINTS) : bus.wdata[PW:0];
				default:
				begin
				end
			endcase
		end

		nxt_st.rdata = bus.rd ? reg_read(bus.addr, st_ff) : 32'h0;
		nxt_st.busy  = nxt_st.fsm == ASG_ACQ || nxt_st.fsm == ASG_DUMP;
	end

	// ----------------------------------------
	// Registers and accumulation buffer
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			st_ff       <= '0;
			st_ff.decim <= `ASG_DECIM_RST;
			st_ff.scans <= `ASG_SCANS_RST;
			st_ff.gain  <= `ASG_GAIN_RST;
			st_ff.npts  <= (PW+1)'(POINTS);
			st_ff.tx    <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	// Read-modify-write accumulation memory
	always_ff @(posedge clk)
	begin
		if (mem_we)
			acc_mem[mem_addr] <= mem_wdata;
		mem_rd_ff <= acc_mem[mem_addr];
	end

	// Output buffer towards the host port
	asg_fifo #(
		.WIDTH (32),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (fifo_in_valid),
		.in_data   (mem_rd_ff),
		.in_ready  (fifo_in_ready),
		.out_valid (host_out.valid),
		.out_data  (host_out.data),
		.out_ready (host_ready)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_tick_gap;
		!tick [*4] ##1 tick;
	endsequence

	sequence s_start_bit;
		!link_tx ##1 !link_tx;
	endsequence

	a_ref_tick_rate: assert property (tick |=> s_tick_gap)
		else $error("reference tick period wrong");
	a_store_dwell: assert property (mem_we |-> front.dwell_enable && $past(st_ff.div) == 3'd1)
		else $error("store outside dwell tick");
	a_zero_gate: assert property (take && !front.converter_gate && !box_full |=>
		st_ff.box_sum == $past(st_ff.box_sum))
		else $error("gated sample not zero");
	a_scan_count: assert property (scan_end |=> st_ff.scan_cnt == $past(st_ff.scan_cnt) + 16'd1)
		else $error("scan count not advanced");
	a_decim_one: assert property (take && st_ff.decim == 8'd1 |-> box_full)
		else $error("decimation by one missed");
	a_phase_step: assert property (scan_end |=> st_ff.phase == $past(st_ff.phase) + 2'd1)
		else $error("phase not stepped");
	a_link_start: assert property ($rose(link_oe) |-> s_start_bit)
		else $error("frame lacks start bit");
	a_dump_enter: assert property (scan_end && last_scan |=> st_ff.fsm == ASG_DUMP ##1 fifo_in_valid)
		else $error("dump not started");
	a_auto_gain_down: assert property (scan_end && st_ff.auto_gain && st_ff.peak > `ASG_PEAK_HI
		&& st_ff.gain != 7'h0 && !bus.wr |=> st_ff.gain == $past(st_ff.gain) - 7'd1 && st_ff.pend_gain)
		else $error("auto gain not lowered");
	a_point_hold: assert property (st_ff.fsm == ASG_ACQ && !mem_we && !scan_end |=> $stable(st_ff.point))
		else $error("point moved without store");
	a_read_once: assert property (!bus.rd |=> rdata == 32'h0)
		else $error("read data outside slot");
endmodule : asg_acq_gate

`default_nettype wire

// >>> asg_acq_gate_tb.sv
`default_nettype none
`include "asg_defs.svh"

module asg_acq_gate_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import asg_pkg::*;

	localparam int NPTS = 20;

	typedef struct packed { logic [7:0] addr; logic [31:0] val; } asg_row_type;

	logic          clk;
	logic          reset;
	asg_front_type front;
	asg_bus_type   bus;
	logic [31:0]   rdata;
	asg_host_type  host_out;
	logic          host_ready;
	logic          link_tx;
	logic          link_oe;
	logic          acq_busy;
	logic          go;
	logic [3:0]    nscan;
	logic [5:0]    nsmp;
	logic [31:0]   v;
	int            bad_count;
	int            compares;

	// Register values after reset, unmapped address last
	asg_row_type rows [6] = '{'{`ASG_REG_CTRL, 32'h100}, '{`ASG_REG_SCANS, 32'h1},
		'{`ASG_REG_GAIN, 32'h20}, '{`ASG_REG_STATUS, 32'h0}, '{`ASG_REG_POINTS, 32'(NPTS)}, '{8'h18, 32'h0}};

	asg_acq_gate #(.POINTS(NPTS), .FIFO_DEPTH(16)) asg_acq_gate_i (.clk(clk), .reset(reset), .front(front),
		.bus(bus), .rdata(rdata), .host_out(host_out), .host_ready(host_ready), .link_tx(link_tx),
		.link_oe(link_oe), .acq_busy(acq_busy));

	asg_far_model asg_far_model_i (.clk(clk), .reset(reset), .go(go), .nscan(nscan), .nsmp(nsmp), .front(front));

	// 100 MHz clock
	always #5 clk = ~clk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task automatic timeout();
		chk(32'h0, 32'h1);
		finish_test();
	endtask : timeout

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask : rd

	task automatic do_reset();
		reset <= 1'b1;
		go    <= 1'b0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
	endtask : do_reset

	// Gated, phase-cycled, decimated sum that point p should hold
	function automatic logic [31:0] exp_pt(input int p, input int dec, input int sc);
		logic [31:0] s;
		logic [31:0] w;
		s = 32'h0;
		for (int i = 0; i < sc; i++)
			for (int k = 0; k < dec; k++)
			begin
				w = (p * dec + k == 2) ? 32'h0 : 32'(256 * (i + 1) + p * dec + k);
				s = (i % 4 >= 2) ? s - w : s + w;
			end
		return s;
	endfunction : exp_pt

	// One acquisition, host stalled first so the FIFO fills when np exceeds 16, then drained
	task automatic run(input int sc, input int dec, input int np, input int ns, input logic ag);
		int n;
		int t;
		wr(`ASG_REG_SCANS, 32'(sc));
		wr(`ASG_REG_POINTS, 32'(np));
		nscan <= 4'(sc);
		nsmp  <= 6'(ns);
		wr(`ASG_REG_CTRL, 32'(dec << 8) | (32'(ag) << 1) | 32'h1);
		go <= 1'b1;
		repeat (3) @(negedge clk);
		chk(32'(acq_busy), 32'h1);
		n = 0;
		t = 0;
		while (n < np)
		begin
			@(negedge clk);
			if (t == 600)
				chk(32'({host_out.valid, acq_busy}), 32'({1'b1, np > 16}));
			if (host_out.valid && host_ready)
			begin
				chk(host_out.data, exp_pt(n, dec, sc));
				n++;
			end
			@(posedge clk);
			host_ready <= (t > 600) && (t % 3 != 0);
			t++;
			if (t > 5000)
				timeout();
		end
		host_ready <= 1'b0;
		repeat (20) @(posedge clk);
		chk(32'(host_out.valid), 32'h0);
		rd(`ASG_REG_STATUS, v);
		chk(v, (32'(sc) << 16) | 32'h0b);
		rd(`ASG_REG_GAIN, v);
		chk(v, 32'(`ASG_GAIN_RST));
	endtask : run

	// Serial frame: start, type, 23 data bits LSB first, stop; after skips the frame on the line
	task automatic chk_frame(input logic after, input logic typ, input logic [22:0] d);
		logic [25:0] f;
		int t;
		f = {1'b1, d, typ, 1'b0};
		t = 0;
		while (after && link_oe === 1'b1)
		begin
			@(negedge clk);
			t++;
			if (t > 300)
				timeout();
		end
		while (link_oe !== 1'b1)
		begin
			@(negedge clk);
			t++;
			if (t > 600)
				timeout();
		end
		repeat (50) @(negedge clk);
		for (int b = 0; b < 26; b++)
		begin
			chk(32'({link_oe, link_tx}), 32'({1'b1, f[b]}));
			if (b < 25)
				repeat (100) @(negedge clk);
		end
	endtask : chk_frame

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		reset = 1'b1;
		go = 1'b0;
		nscan = 4'h0;
		nsmp = 6'h0;
		bus = '0;
		host_ready = 1'b0;
		bad_count = 0;
		compares = 0;
		do_reset();
		chk(rdata, 32'h0);
		chk(32'({host_out.valid, link_oe, link_tx, acq_busy}), 32'h2);
		$display("test reset done");
		foreach (rows[i])
		begin
			rd(rows[i].addr, v);
			chk(v, rows[i].val);
		end
		$display("test registers done");
		run(2, 1, NPTS, NPTS + 2, 1'b0);
		$display("test store and fifo done");
		do_reset();
		run(3, 2, 4, 10, 1'b1);
		$display("test decimation done");
		wr(`ASG_REG_GAIN, 32'h55);
		wr(`ASG_REG_ADJ, 32'h00ab_cdef);
		chk_frame(1'b0, 1'b0, 23'h55);
		chk_frame(1'b1, 1'b1, 23'h2b_cdef);
		repeat (100) @(negedge clk);
		chk(32'({link_oe, link_tx}), 32'h1);
		$display("test link done");
		finish_test();
	end
endmodule : asg_acq_gate_tb

`default_nettype wire

// >>> asg_defs.svh
`ifndef ASG_DEFS_SVH
`define ASG_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define ASG_CLK_HZ        100000000
`define ASG_CLK_NS        10
`define ASG_REF_HZ        20000000
`define ASG_TICK_DIV      (`ASG_CLK_HZ / `ASG_REF_HZ)
`define ASG_LINK_BIT_NS   1000
`define ASG_LINK_BIT_CYC  (`ASG_LINK_BIT_NS / `ASG_CLK_NS)
`define ASG_FRAME_BITS    5'd26

// ----------------------------------------
// Widths
// ----------------------------------------
`define ASG_SAMPLE_W      12

// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define ASG_REG_CTRL      8'h00
`define ASG_REG_SCANS     8'h04
`define ASG_REG_GAIN      8'h08
`define ASG_REG_ADJ       8'h0c
`define ASG_REG_STATUS    8'h10
`define ASG_REG_POINTS    8'h14
`define ASG_CTRL_START    0
`define ASG_CTRL_AUTO     1
`define ASG_CTRL_DEC_LSB  8

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define ASG_DECIM_RST     8'h01
`define ASG_SCANS_RST     16'h0001
`define ASG_GAIN_RST      7'h20
`define ASG_GAIN_MAX      7'h7f
`define ASG_PEAK_HI       12'h700
`define ASG_PEAK_LO       12'h100

`endif

// >>> asg_far_model.sv
`default_nettype none

module asg_far_model
(
	input  wire logic           clk,
	input  wire logic           reset,
	input  wire logic           go,
	input  wire logic [3:0]     nscan,
	input  wire logic [5:0]     nsmp,
	output var asg_pkg::asg_front_type front
);
	timeunit 1ns;
	timeprecision 1ps;
	import asg_pkg::*;

	logic [2:0] tick_ff;
	logic [3:0] scan_ff;
	logic [5:0] idx_ff;

	// Digitizer and timing generator, one slot per 20 MHz tick
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tick_ff <= 3'h0;
			scan_ff <= 4'h0;
			idx_ff  <= 6'h0;
			front   <= '0;
		end
		else
		begin
			tick_ff <= (tick_ff == 3'h4) ? 3'h0 : tick_ff + 3'h1;
			if (tick_ff == 3'h0 && go && scan_ff < nscan)
			begin
				front.receiver_open_gate <= (idx_ff < nsmp);
				if (idx_ff < nsmp)
				begin
					front.dwell_enable   <= 1'b1;
					front.converter_gate <= (idx_ff != 6'h2);
					front.data           <= {scan_ff + 4'h1, 2'h0, idx_ff};
				end
				else
				begin
					// Dwell closed: junk on the line that must be ignored
					front.dwell_enable <= 1'b0;
					front.data         <= ~front.data;
				end
				idx_ff <= (idx_ff == nsmp + 6'h2) ? 6'h0 : idx_ff + 6'h1;
				if (idx_ff == nsmp + 6'h2)
					scan_ff <= scan_ff + 4'h1;
			end
			else if (tick_ff == 3'h0)
				front.data <= ~front.data;
		end
	end
endmodule : asg_far_model

`default_nettype wire

// >>> asg_fifo.sv
`default_nettype none

module asg_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
)(
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	import asg_pkg::*;

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0]  wptr;
		logic [AW-1:0]  rptr;
		logic [AW:0]    cnt;
		logic           ov;
		logic [WIDTH-1:0] od;
	} asg_fifo_state_type;

	asg_fifo_state_type st_ff;
	asg_fifo_state_type nxt_st;
	logic [WIDTH-1:0]   mem [DEPTH];
	logic               push;
	logic               pop;

	// Handshakes
	assign in_ready  = st_ff.cnt < (AW+1)'(DEPTH);
	assign push      = in_valid && in_ready;
	assign pop       = (st_ff.cnt != '0) && (!st_ff.ov || out_ready);
	assign out_valid = st_ff.ov;
	assign out_data  = st_ff.od;

	// Pointer and output stage update
	always_comb
	begin
		nxt_st = st_ff;
		if (push)
			nxt_st.wptr = st_ff.wptr + AW'(1);
		if (pop)
		begin
			nxt_st.od   = mem[st_ff.rptr];
			nxt_st.ov   = 1'b1;
			nxt_st.rptr = st_ff.rptr + AW'(1);
		end
		else if (out_ready)
			nxt_st.ov = 1'b0;
		unique case ({push, pop})
			2'b10:   nxt_st.cnt = st_ff.cnt + (AW+1)'(1);
			2'b01:   nxt_st.cnt = st_ff.cnt - (AW+1)'(1);
			default: nxt_st.cnt = st_ff.cnt;
		endcase
	end

	// State register and storage
	always_ff @(posedge clk)
	begin
		if (reset)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
		if (push)
			mem[st_ff.wptr] <= in_data;
	end
endmodule : asg_fifo

`default_nettype wire

// >>> asg_pkg.sv
`default_nettype none
`include "asg_defs.svh"

package asg_pkg;
	// Sequencer states
	typedef enum logic [1:0]
	{
		ASG_IDLE = 2'b00,
		ASG_ACQ  = 2'b01,
		ASG_DUMP = 2'b10,
		ASG_DONE = 2'b11
	} asg_fsm_type;

	// Digitizer stream with its gates
	typedef struct packed {
		logic                      dwell_enable;
		logic                      converter_gate;
		logic                      receiver_open_gate;
		logic [`ASG_SAMPLE_W-1:0]  data;
	} asg_front_type;

	// Register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} asg_bus_type;

	// Host data word
	typedef struct packed {
		logic [31:0] data;
		logic        valid;
	} asg_host_type;
endpackage : asg_pkg

`default_nettype wire
